// *** src/multiphase_fault_protection.v ***
// fault supervisor: power good, phase drive, crowbar, hiccup retry
`timescale 1ns/10ps
`default_nettype none
`include "fault_prot_regs.vh"
module multiphase_fault_protection (
	// clock and reset
	input  wire                    clk,
	input  wire                    sys_rst,
	// switching cycle tick from the internal pwm clock
	input  wire                    cycleTick,
	// enables and bias state (pins)
	input  wire                    analogEnableIn,
	input  wire                    logic_enable_in,
	input  wire                    biasValidIn,
	input  wire                    biasAuxIn,
	input  wire [`CODE_WIDTH-1:0]  voltage_id_code,
	// target level in mV for the current code
	input  wire [`MV_WIDTH-1:0]    targetMv,
	// digitised sense voltages in mV
	input  wire [`MV_WIDTH-1:0]    output_sense_in,
	input  wire [`MV_WIDTH-1:0]    diff_sense_voltage,
	// current comparators
	input  wire                    average_phase_current,
	input  wire [`NUM_PHASES-1:0]  phaseOverIn,
	// outputs
	output reg                     power_good_out,
	output reg                     pgoodOe_n,
	output reg                     pwmForceLow,
	output reg                     pwmHighZ,
	output reg                     crowbar_drive_out,
	output reg                     driver_enable_out,
	output reg  [`MV_WIDTH-1:0]    rampLevel,
	output reg                     ovTripLevelValid,
	output reg  [`MV_WIDTH-1:0]    ovTripLevel
);
	localparam ST_OFF   = 3'h0;
	localparam ST_DELAY = 3'h1;
	localparam ST_RAMP  = 3'h2;
	localparam ST_RUN   = 3'h3;
	localparam ST_OC    = 3'h4;
	localparam ST_OV    = 3'h5;

	wire [`NUM_PHASES+4:0] syncBits;
	input_sync #(.WIDTH(`NUM_PHASES+5)) uSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn ({phaseOverIn, average_phase_current, biasAuxIn, biasValidIn, logic_enable_in, analogEnableIn}),
		.syncOut (syncBits)
	);
	wire enA    = syncBits[0];
	wire enL    = syncBits[1];
	wire bValid = syncBits[2];
	wire bAux   = syncBits[3];
	wire avgOc  = syncBits[4];
	wire [`NUM_PHASES-1:0] phOver = syncBits[`NUM_PHASES+4:5];

	reg [2:0]             state_reg;
	reg [2:0]             state_next;
	reg [12:0]            cnt_reg;
	reg [12:0]            cnt_next;
	reg                   ovLatch_reg;
	reg                   ovHold_reg;
	reg                   ssDone_reg;
	reg [`MV_WIDTH-1:0]   ramp_next;
	reg [`MV_WIDTH-1:0]   trip_next;

	wire noLoad  = (voltage_id_code == `CODE_NO_LOAD);
	wire enabled = enA && enL && bValid && !noLoad;
	wire hardOff = !enA || !enL || !bValid;

	wire [`MV_WIDTH-1:0] tgtPlus = targetMv + `OV_MARGIN_MV;
	wire [13:0] uvScaled = {2'b00, targetMv} * `UV_NUM;
	wire underV = ({output_sense_in, 2'b00} < uvScaled);

	always @* begin
		trip_next = `OV_PRE_MV;
		if (!bValid) begin
			trip_next = `OV_AUX_MV;
		end else if (ovLatch_reg) begin
			trip_next = tgtPlus;
		end else if (state_reg == ST_DELAY || state_reg == ST_RAMP) begin
			trip_next = (tgtPlus > `OV_SS_FLOOR_MV) ? tgtPlus : `OV_SS_FLOOR_MV;
		end else if (state_reg == ST_RUN) begin
			trip_next = tgtPlus;
		end
	end
	wire [`MV_WIDTH-1:0] senseV = bValid ? diff_sense_voltage : output_sense_in;
	wire overV  = (bValid || bAux) && (senseV > trip_next);

	wire phaseTrip;
	phase_oc_counter uPhOc (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.cycleTick (cycleTick),
		.clearIn   (state_reg != ST_RUN && state_reg != ST_RAMP),
		.phaseOver (phOver),
		.phaseTrip (phaseTrip)
	);
	wire ocTrip = (avgOc || phaseTrip) && (state_reg == ST_RAMP || state_reg == ST_RUN);

	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		ramp_next  = rampLevel;
		case (state_reg)
			ST_OFF: begin
				ramp_next = 12'h000;
				if (enabled && !ovLatch_reg) begin
					state_next = ST_DELAY;
					cnt_next   = 13'h0000;
				end
			end
			ST_DELAY: begin
				if (cycleTick) begin
					cnt_next = cnt_reg + 13'h0001;
				end
				if (cycleTick && cnt_reg == {6'h00, `SS_DELAY_CYCLES} - 13'h0001) begin
					state_next = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (cycleTick && rampLevel < targetMv) begin
					ramp_next = rampLevel + `RAMP_STEP_MV;
				end
				if (rampLevel >= targetMv) begin
					ramp_next  = targetMv;
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				ramp_next = targetMv;
			end
			ST_OC: begin
				if (cycleTick) begin
					cnt_next = cnt_reg + 13'h0001;
				end
				if (cycleTick && cnt_reg == `HICCUP_CYCLES - 13'h0001) begin
					state_next = enabled ? ST_DELAY : ST_OFF;
					cnt_next   = 13'h0000;
					ramp_next  = 12'h000;
				end
			end
			ST_OV: begin
				ramp_next = 12'h000;
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
		if (state_reg != ST_OFF && state_reg != ST_OV && !enabled) begin
			state_next = ST_OFF;
		end else if (overV && state_reg != ST_OFF) begin
			state_next = ST_OV;
		end else if (ocTrip) begin
			state_next = ST_OC;
			cnt_next   = 13'h0000;
		end
		// overvoltage halts until enables or bias cycle
		if (state_reg == ST_OV && hardOff) begin
			state_next = ST_OFF;
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg         <= ST_OFF;
			cnt_reg           <= 13'h0000;
			ovLatch_reg       <= 1'b0;
			ovHold_reg        <= 1'b0;
			ssDone_reg        <= 1'b0;
			rampLevel         <= 12'h000;
			ovTripLevel       <= `OV_PRE_MV;
			ovTripLevelValid  <= 1'b0;
			power_good_out    <= 1'b0;
			pgoodOe_n         <= 1'b0;
			pwmForceLow       <= 1'b0;
			pwmHighZ          <= 1'b1;
			crowbar_drive_out <= 1'b0;
			driver_enable_out <= 1'b0;
		end else begin
			state_reg        <= state_next;
			cnt_reg          <= cnt_next;
			rampLevel        <= ramp_next;
			ovTripLevel      <= trip_next;
			ovTripLevelValid <= bValid || bAux;
			// latch cleared only by disable or bias loss
			if (overV) begin
				ovLatch_reg <= 1'b1;
			end else if (hardOff) begin
				ovLatch_reg <= 1'b0;
			end
			// force low on every overvoltage onset
			if (overV) begin
				ovHold_reg <= 1'b1;
			end else if (senseV < (bValid ? `OV_RELEASE_MV : `OV_RELEASE_NV) ||
					(bValid && diff_sense_voltage <= targetMv)) begin
				// release at reference or below 0.6V with bias valid, below 1.5V without
				ovHold_reg <= 1'b0;
			end
			if (state_next == ST_RUN) begin
				ssDone_reg <= 1'b1;
			end else if (!enabled || state_next == ST_OC || state_next == ST_DELAY) begin
				ssDone_reg <= 1'b0;
			end
			// power good from soft-start and undervoltage
			power_good_out <= (ssDone_reg || state_next == ST_RUN) && enabled && !underV;
			pgoodOe_n      <= (ssDone_reg || state_next == ST_RUN) && enabled && !underV;
			crowbar_drive_out <= overV || ovHold_reg;
			pwmForceLow       <= overV || ovHold_reg;
			// high-impedance unless regulating or forcing low
			pwmHighZ <= !(overV || ovHold_reg) && state_next != ST_RUN && state_next != ST_RAMP;
			if (overV || ovHold_reg || state_next == ST_OV) begin
				driver_enable_out <= output_sense_in > `OV_RELEASE_MV;
			end else begin
				driver_enable_out <= (state_next == ST_RAMP || state_next == ST_RUN) && !ocTrip;
			end
		end
	end
endmodule // multiphase_fault_protection
`default_nettype wire

// *** src/fault_prot_regs.vh ***
// constants for the multiphase fault supervisor
`ifndef FAULT_PROT_REGS_VH
`define FAULT_PROT_REGS_VH
`define NUM_PHASES      4
`define CODE_WIDTH      6
`define CODE_NO_LOAD    6'h3f
`define MV_WIDTH        12
`define UV_NUM          14'h0003
`define UV_SHIFT        2
`define OV_AUX_MV       12'h708
`define OV_PRE_MV       12'h6a4
`define OV_SS_FLOOR_MV  12'h5dc
`define OV_MARGIN_MV    12'h0c8
`define OV_RELEASE_MV   12'h258
`define OV_RELEASE_NV   12'h5dc
`define PHASE_OC_CYCLES 4'h8
`define HICCUP_CYCLES   13'h1000
`define SS_DELAY_CYCLES 7'h40
`define RAMP_STEP_MV    12'h001
`endif

// *** src/input_sync.v ***
// three-flop synchroniser that passes a change once two stages agree
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             sys_rst,
	// asynchronous input and filtered output
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1Reg;
	reg [WIDTH-1:0] stage2Reg;
	reg [WIDTH-1:0] stage3Reg;
	genvar i;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1Reg <= {WIDTH{1'b0}};
			stage2Reg <= {WIDTH{1'b0}};
			stage3Reg <= {WIDTH{1'b0}};
		end else begin
			stage1Reg <= asyncIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
		end
	end
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					syncOut[i] <= 1'b0;
				end else if (stage2Reg[i] == stage3Reg[i]) begin
					syncOut[i] <= stage3Reg[i];
				end
			end
		end
	endgenerate
endmodule // input_sync
`default_nettype wire

// *** src/phase_oc_counter.v ***
// per-phase sustained overcurrent detector, one counter per phase
`timescale 1ns/10ps
`default_nettype none
`include "fault_prot_regs.vh"
module phase_oc_counter (
	// clock and reset
	input  wire                    clk,
	input  wire                    sys_rst,
	// switching cycle tick and phase comparators
	input  wire                    cycleTick,
	input  wire                    clearIn,
	input  wire [`NUM_PHASES-1:0]  phaseOver,
	// any phase sustained over reference
	output wire                    phaseTrip
);
	wire [`NUM_PHASES-1:0] hit;
	genvar i;
	generate
		for (i = 0; i < `NUM_PHASES; i = i + 1) begin : gPh
			reg [3:0] cnt_reg;
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_reg <= 4'h0;
				end else if (clearIn || !phaseOver[i]) begin
					cnt_reg <= 4'h0;
				end else if (cycleTick && cnt_reg != `PHASE_OC_CYCLES) begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
			assign hit[i] = (cnt_reg == `PHASE_OC_CYCLES);
		end
	endgenerate
	assign phaseTrip = |hit;
endmodule // phase_oc_counter
`default_nettype wire

// *** tb/fault_prot_properties.sv ***
// port checker for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
`include "fault_prot_regs.vh"
module fault_prot_properties (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 sys_rst,
	// inputs
	input wire logic                 cycleTick,
	input wire logic [`MV_WIDTH-1:0] targetMv,
	input wire logic [`MV_WIDTH-1:0] output_sense_in,
	input wire logic [`MV_WIDTH-1:0] diff_sense_voltage,
	input wire logic                 average_phase_current,
	// outputs
	input wire logic                 power_good_out,
	input wire logic                 pgoodOe_n,
	input wire logic                 pwmForceLow,
	input wire logic                 pwmHighZ,
	input wire logic                 crowbar_drive_out,
	input wire logic                 driver_enable_out,
	input wire logic                 ovTripLevelValid,
	input wire logic [`MV_WIDTH-1:0] ovTripLevel
);
	logic [12:0] offTicks_reg;
	// clearly under three quarters, so rounding of the threshold cannot matter
	wire uvLow = ({2'b00, output_sense_in, 2'b00} + 16'h0004) <= ({4'h0, targetMv} * 16'h0003);
	wire ovHigh = ovTripLevelValid && (diff_sense_voltage > ovTripLevel);
	sequence ocHeld;
		average_phase_current [*4];
	endsequence
	sequence phasesRunning;
		average_phase_current && driver_enable_out && !pwmHighZ && !pwmForceLow;
	endsequence
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ticks seen while the driver enable is low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			offTicks_reg <= 13'h0000;
		else
			offTicks_reg <= driver_enable_out ? 13'h0000 : offTicks_reg + {12'h000, cycleTick && !(&offTicks_reg)};
	end
	power_good_out_pin_a: assert property (pgoodOe_n == power_good_out) else $error("power_good_out enable differs");
	uv_power_good_out_a: assert property (uvLow [*2] |=> !power_good_out) else $error("power_good_out kept in undervoltage");
	ov_crowbar_a: assert property (ovHigh [*2] |=> crowbar_drive_out) else $error("no crowbar on trip");
	force_crowbar_a: assert property ($rose(pwmForceLow) |-> crowbar_drive_out) else $error("crowbar late");
	force_float_a: assert property (!(pwmForceLow && pwmHighZ)) else $error("low and float together");
	oc_drv_a: assert property (ocHeld ##0 phasesRunning |-> ##2 !driver_enable_out) else $error("drv kept on oc");
	start_delay_a: assert property ($rose(driver_enable_out) |-> offTicks_reg >= 13'h0040) else $error("delay short");
	run_trip_a: assert property (power_good_out ##1 (power_good_out && $stable(targetMv))
		|-> ovTripLevel == targetMv + 12'h0c8) else $error("run trip level wrong");
endmodule // fault_prot_properties
bind multiphase_fault_protection fault_prot_properties fault_prot_properties_i (
	.clk(clk), .sys_rst(sys_rst), .cycleTick(cycleTick), .targetMv(targetMv),
	.output_sense_in(output_sense_in), .diff_sense_voltage(diff_sense_voltage),
	.average_phase_current(average_phase_current), .power_good_out(power_good_out),
	.pgoodOe_n(pgoodOe_n), .pwmForceLow(pwmForceLow), .pwmHighZ(pwmHighZ),
	.crowbar_drive_out(crowbar_drive_out), .driver_enable_out(driver_enable_out),
	.ovTripLevelValid(ovTripLevelValid), .ovTripLevel(ovTripLevel));
`default_nettype wire

// *** tb/driver_monitor_model.sv ***
// gate driver and system monitor seen from the supervisor pins
`timescale 1ns/10ps
`default_nettype none
module driver_monitor_model (
	// supervisor outputs
	input  wire logic pgoodOe_n,
	input  wire logic pwmForceLow,
	input  wire logic pwmHighZ,
	input  wire logic driver_enable_out,
	// resolved pins
	output wire logic pgoodPin,
	output wire logic lowFetOn
);
	assign pgoodPin = pgoodOe_n ? 1'b1 : 1'b0;
	// lower switch only when driven low and enabled
	assign lowFetOn = pwmForceLow && driver_enable_out && !pwmHighZ;
endmodule // driver_monitor_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, sys_rst = 1'b1, cycleTick = 1'b0, analogEnableIn = 1'b0, logic_enable_in = 1'b0;
	logic        biasValidIn = 1'b1, biasAuxIn = 1'b1, average_phase_current = 1'b0;
	logic [5:0]  voltage_id_code = 6'h10;
	logic [11:0] targetMv = 12'h4b0, output_sense_in = 12'h4b0, diff_sense_voltage = 12'h4b0;
	logic [3:0]  phaseOverIn = 4'h0;
	wire         power_good_out, pgoodOe_n, pwmForceLow, pwmHighZ, crowbar_drive_out, driver_enable_out;
	wire         ovTripLevelValid, pgoodPin;
	wire  [11:0] rampLevel, ovTripLevel;
	wire  [5:0]  st = {pgoodPin, pgoodOe_n, pwmForceLow, pwmHighZ, crowbar_drive_out, driver_enable_out};
	logic [36:0] noteQ[$];
	int          error_cnt = 0, n_tests = 0, k;
	event        sampleEv;
	multiphase_fault_protection multiphase_fault_protection_i (
		.clk(clk), .sys_rst(sys_rst), .cycleTick(cycleTick), .analogEnableIn(analogEnableIn),
		.logic_enable_in(logic_enable_in), .biasValidIn(biasValidIn), .biasAuxIn(biasAuxIn),
		.voltage_id_code(voltage_id_code), .targetMv(targetMv), .output_sense_in(output_sense_in),
		.diff_sense_voltage(diff_sense_voltage), .average_phase_current(average_phase_current),
		.phaseOverIn(phaseOverIn), .power_good_out(power_good_out), .pgoodOe_n(pgoodOe_n),
		.pwmForceLow(pwmForceLow), .pwmHighZ(pwmHighZ), .crowbar_drive_out(crowbar_drive_out),
		.driver_enable_out(driver_enable_out), .rampLevel(rampLevel),
		.ovTripLevelValid(ovTripLevelValid), .ovTripLevel(ovTripLevel));
	driver_monitor_model driver_monitor_model_i (
		.pgoodOe_n(pgoodOe_n), .pwmForceLow(pwmForceLow), .pwmHighZ(pwmHighZ),
		.driver_enable_out(driver_enable_out), .pgoodPin(pgoodPin), .lowFetOn());
	always #20 clk = ~clk;
	// one switching tick every second clock
	always @(negedge clk) cycleTick <= ~cycleTick;
	task check(input logic [11:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task note(input logic sel, input logic [11:0] m, e, v);
		noteQ.push_back({sel, m, e, v});
		->sampleEv;
		#1;
	endtask
	task stat(input logic [5:0] m, e);
		note(1'b0, {6'h00, m}, {6'h00, e}, 12'h000);
	endtask
	task waitSt(input int i, input logic v, input int lim);
		k = 0;
		while (st[i] !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
	endtask
	task pause(input int n);
		repeat (n) @(negedge clk);
	endtask
	always @(sampleEv) begin : monitor
		logic [36:0] n;
		n = noteQ.pop_front();
		check((n[36] ? n[11:0] : {6'h00, st}) & n[35:24], n[23:12]);
	end
	task final_report();
		if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#1600000;
		error_cnt++;
		final_report();
	end
	initial begin
		void'($urandom(11));
		pause(3);
		sys_rst = 1'b0;
		pause(6);
		stat(6'h3f, 6'h04);
		note(1'b1, 12'hfff, 12'h6a4, ovTripLevel);
		analogEnableIn = 1'b1;
		logic_enable_in = 1'b1;
		waitSt(0, 1'b1, 400);
		note(1'b1, 12'h001, 12'h001, {11'h000, k >= 128});
		stat(6'h25, 6'h01);
		waitSt(5, 1'b1, 3000);
		stat(6'h3f, 6'h31);
		pause(4);
		note(1'b1, 12'hfff, 12'h578, ovTripLevel);
		output_sense_in = 12'h320;
		pause(8);
		stat(6'h30, 6'h00);
		output_sense_in = 12'h4b0;
		pause(8);
		stat(6'h30, 6'h30);
		diff_sense_voltage = 12'h5dc;
		pause(8);
		stat(6'h3f, 6'h3b);
		diff_sense_voltage = 12'h4b0;
		pause(8);
		stat(6'h0d, 6'h05);
		diff_sense_voltage = 12'h5dc;
		pause(8);
		stat(6'h0e, 6'h0a);
		diff_sense_voltage = 12'h4b0;
		output_sense_in = 12'h1f4;
		pause(8);
		stat(6'h0d, 6'h04);
		voltage_id_code = 6'h3f;
		pause(10);
		voltage_id_code = 6'h10;
		pause(300);
		stat(6'h0d, 6'h04);
		logic_enable_in = 1'b0;
		output_sense_in = 12'h4b0;
		pause(8);
		stat(6'h30, 6'h00);
		logic_enable_in = 1'b1;
		waitSt(5, 1'b1, 3200);
		stat(6'h3f, 6'h31);
		voltage_id_code = 6'h3f;
		pause(10);
		stat(6'h30, 6'h00);
		voltage_id_code = 6'h10;
		waitSt(5, 1'b1, 3200);
		stat(6'h30, 6'h30);
		average_phase_current = 1'b1;
		pause(8);
		stat(6'h05, 6'h04);
		average_phase_current = 1'b0;
		waitSt(5, 1'b1, 12000);
		note(1'b1, 12'h001, 12'h001, {11'h000, k >= 8320});
		stat(6'h3f, 6'h31);
		phaseOverIn = 4'h1 << ($urandom % 4);
		pause(30);
		stat(6'h05, 6'h04);
		phaseOverIn = 4'h0;
		final_report();
	end
endmodule // tb_top
`default_nettype wire
